// *** sfd_device.sv ***
`timescale 1ns/10ps
`include "sfd_map.svh"
module sfd_device #(
  parameter int unsigned ADDR_W = `SFD_ADDR_W,
  parameter logic [7:0]  MAN_ID = `SFD_MAN_ID, // arbitrary value
  parameter logic [7:0]  DEV_ID = `SFD_DEV_ID  // arbitrary value
) (
  // system
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  input  wire logic ce_in,
  // serial link
  sfd_if.dev        spi,
  // state
  output logic      busy_out,
  output logic      write_latch_out,
  output logic      ainc_mode_out,
  output logic      ready_not_busy_en_out
);
  localparam int unsigned DEPTH = 1 << ADDR_W;

  logic [7:0]        mem_q [DEPTH];
  logic [2:0]        bit_q;
  logic [2:0]        byte_q;
  logic [6:0]        sh_q;
  logic [7:0]        op_q;
  logic [ADDR_W-1:0] adr_q;
  logic [7:0]        d0_q;
  logic              ign_q;
  logic              out_q;
  logic [3:0]        stm_q;
  logic [3:0]        stk_q;
  logic              pv_q;
  logic [7:0]        pop_q;
  logic [ADDR_W-1:0] padr_q;
  logic [7:0]        pd0_q;
  logic [7:0]        pd1_q;
  logic              so_q;
  logic              soe_q;
  logic [7:0]        osr_q;
  logic [1:0]        sm_q;
  logic [1:0]        ss_q;
  logic              csp_q;
  sfd_pkg::sfd_exe_t st_q;
  logic [ADDR_W-1:0] ptr_q;
  logic [ADDR_W-1:0] lim_q;
  logic              pair_q;

  logic [7:0]        byt;
  logic [7:0]        cop;
  logic              last;
  logic              cont;
  logic              bad;
  logic              done;
  logic [3:0]        fin;
  logic [2:0]        hdr;
  logic [ADDR_W-1:0] nadr;
  logic [7:0]        stb;
  logic [7:0]        obyte;
  logic              cs_rise;
  logic [ADDR_W-1:0] msk;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        mem_wd;

  function automatic logic known(input logic [7:0] op);
    case (op)
      `SFD_OP_READ, `SFD_OP_FAST_READ, `SFD_OP_SECT_ERASE,
      `SFD_OP_BLK32_ERASE, `SFD_OP_BLK64_ERASE, `SFD_OP_CHIP_ERASE_A,
      `SFD_OP_CHIP_ERASE_B, `SFD_OP_BYTE_PROG, `SFD_OP_AUTO_INC_PROG,
      `SFD_OP_STATUS_READ, `SFD_OP_STATUS2_READ, `SFD_OP_WRITE_ENABLE,
      `SFD_OP_WRITE_DISABLE, `SFD_OP_ID_READ_A, `SFD_OP_ID_READ_B,
      `SFD_OP_BUSY_OUT_ON, `SFD_OP_BUSY_OUT_OFF: known = 1'b1;
      default: known = 1'b0;
    endcase
  endfunction : known

  // commit flag and index of the byte that completes a write-type command
  function automatic logic [3:0] fin_of(input logic [7:0] op,
                                        input logic       cn);
    case (op)
      `SFD_OP_WRITE_ENABLE, `SFD_OP_WRITE_DISABLE, `SFD_OP_BUSY_OUT_ON,
      `SFD_OP_BUSY_OUT_OFF, `SFD_OP_CHIP_ERASE_A,
      `SFD_OP_CHIP_ERASE_B: fin_of = 4'h8;
      `SFD_OP_SECT_ERASE, `SFD_OP_BLK32_ERASE,
      `SFD_OP_BLK64_ERASE: fin_of = 4'hB;
      `SFD_OP_BYTE_PROG: fin_of = 4'hC;
      `SFD_OP_AUTO_INC_PROG: fin_of = cn ? 4'hA : 4'hD;
      default: fin_of = 4'h0;
    endcase
  endfunction : fin_of

  // bytes before the first output byte of a read-type command
  function automatic logic [2:0] hdr_of(input logic [7:0] op);
    case (op)
      `SFD_OP_READ, `SFD_OP_ID_READ_A, `SFD_OP_ID_READ_B: hdr_of = 3'h4;
      `SFD_OP_FAST_READ: hdr_of = 3'h5;
      `SFD_OP_STATUS_READ, `SFD_OP_STATUS2_READ: hdr_of = 3'h1;
      default: hdr_of = 3'h0;
    endcase
  endfunction : hdr_of

  always_comb begin
    byt  = {sh_q, spi.mosi};
    cop  = (byte_q == 3'h0) ? byt : op_q;
    last = (bit_q == 3'h7);
    cont = stk_q[2] && (cop == `SFD_OP_AUTO_INC_PROG);
    bad  = !known(cop)
         || (stk_q[2] && cop != `SFD_OP_AUTO_INC_PROG
             && cop != `SFD_OP_STATUS_READ
             && cop != `SFD_OP_WRITE_DISABLE);
    fin  = fin_of(cop, cont);
    hdr  = hdr_of(cop);
    nadr = ADDR_W'({adr_q, byt});
    done = last && !ign_q && !bad && fin[3] && byte_q == fin[2:0];
  end

  // status bits from the system domain
  always_ff @(posedge spi.sck) begin
    stm_q <= {ready_not_busy_en_out, ainc_mode_out, write_latch_out,
              busy_out};
    stk_q <= stm_q;
  end

  // byte framing, cleared whenever select is high
  always_ff @(posedge spi.sck or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      bit_q  <= 3'h0;
      byte_q <= 3'h0;
      sh_q   <= 7'h00;
      ign_q  <= 1'b0;
      out_q  <= 1'b0;
    end else begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= byt[6:0];
      if (last) begin
        byte_q <= (byte_q == 3'h7) ? 3'h7 : byte_q + 3'h1;
        if (bad || ign_q)
          ign_q <= 1'b1;
        else if (hdr != 3'h0 && byte_q + 3'h1 == hdr)
          out_q <= 1'b1;
      end
    end
  end

  // opcode, address and first data byte capture
  always_ff @(posedge spi.sck) begin
    if (!spi.cs_n && last) begin
      if (byte_q == 3'h0)
        op_q <= byt;
      if (byte_q != 3'h0 && byte_q < 3'h4 && !cont)
        adr_q <= nadr;
      else if (out_q && op_q != `SFD_OP_ID_READ_A
               && op_q != `SFD_OP_ID_READ_B)
        adr_q <= adr_q + ADDR_W'(1);
      if (cont ? byte_q == 3'h1 : byte_q == 3'h4)
        d0_q <= byt;
    end
  end

  // a command counts only if select rises right after its last bit
  always_ff @(posedge spi.sck or negedge rstn_in) begin
    if (!rstn_in)
      pv_q <= 1'b0;
    else
      pv_q <= done && !spi.cs_n;
  end

  always_ff @(posedge spi.sck) begin
    if (done) begin
      pop_q  <= cop;
      padr_q <= (byte_q == 3'h3) ? nadr : adr_q;
      // single program completes on its data byte, d0_q not yet loaded
      pd0_q  <= (cop == `SFD_OP_BYTE_PROG) ? byt : d0_q;
      pd1_q  <= byt;
    end
  end

  always_comb begin
    stb                  = 8'h00;
    stb[`SFD_ST_BUSY]     = stk_q[0];
    stb[`SFD_ST_LATCH]    = stk_q[1];
    stb[`SFD_ST_AUTO_INC] = stk_q[2];
    case (op_q)
      `SFD_OP_STATUS_READ: obyte = stb;
      `SFD_OP_STATUS2_READ: obyte = 8'h00;
      `SFD_OP_ID_READ_A, `SFD_OP_ID_READ_B:
        obyte = adr_q[0] ? DEV_ID : MAN_ID;
      default: obyte = mem_q[adr_q];
    endcase
  end

  // serial output changes on the falling clock edge
  always_ff @(negedge spi.sck or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      so_q  <= 1'b1;
      soe_q <= 1'b0;
      osr_q <= 8'h00;
    end else if (out_q) begin
      soe_q <= 1'b1;
      if (bit_q == 3'h0) begin
        so_q  <= obyte[7];
        osr_q <= {obyte[6:0], 1'b0};
      end else begin
        so_q  <= osr_q[7];
        osr_q <= {osr_q[6:0], 1'b0};
      end
    end else if (stk_q[3] && stk_q[2]) begin
      soe_q <= 1'b1;
      so_q  <= !stk_q[0];
    end else begin
      soe_q <= 1'b0;
    end
  end

  assign spi.miso    = so_q;
  assign spi.miso_oe = soe_q;

  // select and commit flag into the system domain
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      sm_q  <= 2'h1;
      ss_q  <= 2'h1;
      csp_q <= 1'b1;
    end else if (ce_in) begin
      sm_q  <= {pv_q, spi.cs_n};
      ss_q  <= sm_q;
      csp_q <= ss_q[0];
    end
  end

  always_comb begin
    cs_rise = ss_q[0] && !csp_q;
    case (pop_q)
      `SFD_OP_SECT_ERASE:  msk = ADDR_W'((1 << `SFD_SECT_LSB) - 1);
      `SFD_OP_BLK32_ERASE: msk = ADDR_W'((1 << `SFD_BLK32_LSB) - 1);
      `SFD_OP_BLK64_ERASE: msk = ADDR_W'((1 << `SFD_BLK64_LSB) - 1);
      default:             msk = '1;
    endcase
  end

  // command execution at the end of each frame
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      st_q                  <= sfd_pkg::EX_IDLE;
      write_latch_out       <= 1'b0;
      ainc_mode_out         <= 1'b0;
      ready_not_busy_en_out <= 1'b0;
      ptr_q                 <= '0;
      lim_q                 <= '0;
      pair_q                <= 1'b0;
    end else if (ce_in) begin
      unique case (st_q)
        sfd_pkg::EX_IDLE: begin
          if (cs_rise && ss_q[1]) begin
            case (pop_q)
              `SFD_OP_WRITE_ENABLE: write_latch_out <= 1'b1;
              `SFD_OP_WRITE_DISABLE: begin
                write_latch_out <= 1'b0;
                ainc_mode_out   <= 1'b0;
              end
              `SFD_OP_BUSY_OUT_ON: ready_not_busy_en_out <= 1'b1;
              `SFD_OP_BUSY_OUT_OFF: ready_not_busy_en_out <= 1'b0;
              `SFD_OP_BYTE_PROG: if (write_latch_out) begin
                ptr_q  <= padr_q;
                pair_q <= 1'b0;
                st_q   <= sfd_pkg::EX_WR1;
              end
              `SFD_OP_AUTO_INC_PROG: if (write_latch_out) begin
                if (!ainc_mode_out)
                  ptr_q <= {padr_q[ADDR_W-1:1], 1'b0};
                ainc_mode_out <= 1'b1;
                pair_q        <= 1'b1;
                st_q          <= sfd_pkg::EX_WR1;
              end
              `SFD_OP_SECT_ERASE, `SFD_OP_BLK32_ERASE, `SFD_OP_BLK64_ERASE,
              `SFD_OP_CHIP_ERASE_A, `SFD_OP_CHIP_ERASE_B:
                if (write_latch_out) begin
                  ptr_q <= padr_q & ~msk;
                  lim_q <= padr_q | msk;
                  st_q  <= sfd_pkg::EX_ERASE;
                end
              default: ;
            endcase
          end
        end
        sfd_pkg::EX_WR1: begin
          if (pair_q) begin
            st_q <= sfd_pkg::EX_WR2;
          end else begin
            write_latch_out <= 1'b0;
            st_q            <= sfd_pkg::EX_IDLE;
          end
        end
        sfd_pkg::EX_WR2: begin
          ptr_q <= ptr_q + ADDR_W'(2);
          if (&ptr_q[ADDR_W-1:1]) begin
            ainc_mode_out   <= 1'b0;
            write_latch_out <= 1'b0;
          end
          st_q <= sfd_pkg::EX_IDLE;
        end
        sfd_pkg::EX_ERASE: begin
          ptr_q <= ptr_q + ADDR_W'(1);
          if (ptr_q == lim_q) begin
            write_latch_out <= 1'b0;
            st_q            <= sfd_pkg::EX_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    mem_we = (st_q != sfd_pkg::EX_IDLE);
    mem_wa = ptr_q;
    mem_wd = pd0_q;
    if (st_q == sfd_pkg::EX_WR2) begin
      mem_wa = ptr_q | ADDR_W'(1);
      mem_wd = pd1_q;
    end else if (st_q == sfd_pkg::EX_ERASE) begin
      mem_wd = `SFD_ERASED;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (ce_in && mem_we)
      mem_q[mem_wa] <= mem_wd;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in)
      busy_out <= 1'b0;
    else if (ce_in)
      busy_out <= (st_q != sfd_pkg::EX_IDLE);
  end
endmodule : sfd_device

// *** sfd_map.svh ***
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH
`define SFD_OP_READ           8'h03
`define SFD_OP_FAST_READ      8'h0B
`define SFD_OP_SECT_ERASE     8'h20
`define SFD_OP_BLK32_ERASE    8'h52
`define SFD_OP_BLK64_ERASE    8'hD8
`define SFD_OP_CHIP_ERASE_A   8'h60
`define SFD_OP_CHIP_ERASE_B   8'hC7
`define SFD_OP_BYTE_PROG      8'h02
`define SFD_OP_AUTO_INC_PROG  8'hAD
`define SFD_OP_STATUS_READ    8'h05
`define SFD_OP_STATUS2_READ   8'h35
`define SFD_OP_WRITE_ENABLE   8'h06
`define SFD_OP_WRITE_DISABLE  8'h04
`define SFD_OP_ID_READ_A      8'h90
`define SFD_OP_ID_READ_B      8'hAB
`define SFD_OP_BUSY_OUT_ON    8'h70
`define SFD_OP_BUSY_OUT_OFF   8'h80
`define SFD_ADDR_W            18
`define SFD_SECT_LSB          12
`define SFD_BLK32_LSB         15
`define SFD_BLK64_LSB         16
`define SFD_ERASED            8'hFF
`define SFD_ST_BUSY           0
`define SFD_ST_LATCH          1
`define SFD_ST_AUTO_INC       6
`define SFD_SYS_KHZ           200000
`define SFD_READ_KHZ          33000
`define SFD_FAST_KHZ          80000
`define SFD_SCK_HALF          12
`define SFD_MAN_ID            8'h5A
`define SFD_DEV_ID            8'hC3
`endif

// *** sfd_pkg.sv ***
package sfd_pkg;
  // command execution in the device system domain
  typedef enum logic [1:0] {
    EX_IDLE  = 2'h0,
    EX_WR1   = 2'h1,
    EX_WR2   = 2'h3,
    EX_ERASE = 2'h2
  } sfd_exe_t;
  // host transfer sequencer
  typedef enum logic [1:0] {
    HS_IDLE  = 2'h0,
    HS_SHIFT = 2'h1,
    HS_GAP   = 2'h3
  } sfd_hst_t;
endpackage : sfd_pkg

// *** sfd_if.sv ***
`timescale 1ns/10ps
interface sfd_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic so_line;
  // undriven serial output reads high through the pull-up
  assign so_line = miso_oe ? miso : 1'b1;
  modport dev (input cs_n, sck, mosi, output miso, miso_oe);
  modport host (output cs_n, sck, mosi, input so_line);
endinterface : sfd_if

// *** sfd_host.sv ***
`timescale 1ns/10ps
`include "sfd_map.svh"
module sfd_host #(
  parameter int unsigned HALF = `SFD_SCK_HALF
) (
  // system
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  // command
  input  wire logic        cmd_valid_in,
  input  wire logic [7:0]  cmd_op_in,
  input  wire logic [23:0] cmd_addr_in,
  input  wire logic [15:0] cmd_data_in,
  input  wire logic [7:0]  cmd_rd_len_in,
  output logic             cmd_ready_out,
  output logic             cmd_err_out,
  output logic             done_out,
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  // serial link
  sfd_if.host              spi
);
  localparam int unsigned MIN_RD =
    (`SFD_SYS_KHZ + 2 * `SFD_READ_KHZ - 1) / (2 * `SFD_READ_KHZ);
  localparam int unsigned MIN_FAST =
    (`SFD_SYS_KHZ + 2 * `SFD_FAST_KHZ - 1) / (2 * `SFD_FAST_KHZ);
  localparam int unsigned H_RD = (HALF > MIN_RD) ? HALF : MIN_RD;
  localparam int unsigned H_FA = (HALF > MIN_FAST) ? HALF : MIN_FAST;

  sfd_pkg::sfd_hst_t st_q;
  logic [7:0]  div_q;
  logic [7:0]  half_q;
  logic [55:0] tx_q;
  logic [11:0] nbit_q;
  logic [11:0] hbit_q;
  logic [11:0] bcnt_q;
  logic [7:0]  rx_q;
  logic [1:0]  ms_q;
  logic        wel_q;
  logic        ainc_q;
  logic        cs_q;
  logic        sck_q;
  logic        mosi_q;

  logic        wr;
  logic        rd;
  logic [1:0]  na;
  logic        nd;
  logic [1:0]  nw;
  logic [55:0] txn;
  logic [11:0] nb;
  logic [7:0]  rxn;
  logic        tick;

  always_comb begin
    wr = 1'b0;
    rd = 1'b0;
    case (cmd_op_in)
      `SFD_OP_SECT_ERASE, `SFD_OP_BLK32_ERASE, `SFD_OP_BLK64_ERASE,
      `SFD_OP_CHIP_ERASE_A, `SFD_OP_CHIP_ERASE_B,
      `SFD_OP_BYTE_PROG: wr = 1'b1;
      `SFD_OP_AUTO_INC_PROG: wr = !ainc_q;
      `SFD_OP_READ, `SFD_OP_FAST_READ, `SFD_OP_ID_READ_A,
      `SFD_OP_ID_READ_B, `SFD_OP_STATUS_READ,
      `SFD_OP_STATUS2_READ: rd = 1'b1;
      default: ;
    endcase
    case (cmd_op_in)
      `SFD_OP_READ, `SFD_OP_FAST_READ, `SFD_OP_ID_READ_A,
      `SFD_OP_ID_READ_B, `SFD_OP_SECT_ERASE, `SFD_OP_BLK32_ERASE,
      `SFD_OP_BLK64_ERASE, `SFD_OP_BYTE_PROG: na = 2'h3;
      `SFD_OP_AUTO_INC_PROG: na = ainc_q ? 2'h0 : 2'h3;
      default: na = 2'h0;
    endcase
    nd = (cmd_op_in == `SFD_OP_FAST_READ);
    nw = (cmd_op_in == `SFD_OP_AUTO_INC_PROG) ? 2'h2
       : (cmd_op_in == `SFD_OP_BYTE_PROG) ? 2'h1 : 2'h0;
    if (na == 2'h0)
      txn = {cmd_op_in, cmd_data_in, 32'h0000_0000};
    else if (nd)
      txn = {cmd_op_in, cmd_addr_in, 24'h00_0000};
    else
      txn = {cmd_op_in, cmd_addr_in, cmd_data_in, 8'h00};
    nb   = {7'h00, 3'h1 + 3'(na) + 3'(nd) + 3'(nw), 2'h0} << 1;
    rxn  = {rx_q[6:0], ms_q[1]};
    tick = (div_q == half_q - 8'h01);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in)
      ms_q <= 2'h3;
    else if (ce_in)
      ms_q <= {ms_q[0], spi.so_line};
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      st_q          <= sfd_pkg::HS_IDLE;
      cmd_ready_out <= 1'b1;
      cmd_err_out   <= 1'b0;
      done_out      <= 1'b0;
      rd_data_out   <= 8'h00;
      rd_valid_out  <= 1'b0;
      div_q         <= 8'h00;
      half_q        <= 8'(HALF);
      tx_q          <= '0;
      nbit_q        <= 12'h000;
      hbit_q        <= 12'h000;
      bcnt_q        <= 12'h000;
      rx_q          <= 8'h00;
      wel_q         <= 1'b0;
      ainc_q        <= 1'b0;
      cs_q          <= 1'b1;
      sck_q         <= 1'b0;
      mosi_q        <= 1'b0;
    end else if (ce_in) begin
      cmd_err_out  <= 1'b0;
      done_out     <= 1'b0;
      rd_valid_out <= 1'b0;
      unique case (st_q)
        sfd_pkg::HS_IDLE: begin
          if (cmd_valid_in && wr && !wel_q) begin
            cmd_err_out <= 1'b1;
          end else if (cmd_valid_in) begin
            cmd_ready_out <= 1'b0;
            cs_q          <= 1'b0;
            mosi_q        <= txn[55];
            tx_q          <= {txn[54:0], 1'b0};
            hbit_q        <= nb;
            nbit_q        <= nb + (rd ? {1'b0, cmd_rd_len_in, 3'h0}
                                      : 12'h000);
            bcnt_q        <= 12'h000;
            div_q         <= 8'h00;
            half_q        <= 8'(cmd_op_in == `SFD_OP_READ ? H_RD : H_FA);
            st_q          <= sfd_pkg::HS_SHIFT;
            if (cmd_op_in == `SFD_OP_WRITE_ENABLE)
              wel_q <= 1'b1;
            else if (cmd_op_in == `SFD_OP_WRITE_DISABLE) begin
              wel_q  <= 1'b0;
              ainc_q <= 1'b0;
            end else if (cmd_op_in == `SFD_OP_AUTO_INC_PROG)
              ainc_q <= 1'b1;
            else if (wr)
              wel_q <= 1'b0;
          end
        end
        sfd_pkg::HS_SHIFT: begin
          div_q <= tick ? 8'h00 : div_q + 8'h01;
          if (tick && !sck_q) begin
            sck_q  <= 1'b1;
            rx_q   <= rxn;
            bcnt_q <= bcnt_q + 12'h001;
            if (bcnt_q >= hbit_q && bcnt_q[2:0] == 3'h7) begin
              rd_data_out  <= rxn;
              rd_valid_out <= 1'b1;
            end
          end else if (tick) begin
            sck_q <= 1'b0;
            if (bcnt_q == nbit_q) begin
              cs_q <= 1'b1;
              st_q <= sfd_pkg::HS_GAP;
            end else begin
              mosi_q <= tx_q[55];
              tx_q   <= {tx_q[54:0], 1'b0};
            end
          end
        end
        sfd_pkg::HS_GAP: begin
          div_q <= tick ? 8'h00 : div_q + 8'h01;
          if (tick) begin
            cmd_ready_out <= 1'b1;
            done_out      <= 1'b1;
            st_q          <= sfd_pkg::HS_IDLE;
          end
        end
      endcase
    end
  end

  assign spi.cs_n = cs_q;
  assign spi.sck  = sck_q;
  assign spi.mosi = mosi_q;
endmodule : sfd_host

// *** sfd_checker.sv ***
`timescale 1ns/10ps
module sfd_checker (
  // system
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_oe,
  input wire logic so_line
);
  logic       sck_q;
  logic [7:0] cnt_q;
  logic [7:0] op_q;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge clk_sys_in) begin
    sck_q <= sck;
  end
  // rising link clock edges seen in the current frame
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || cs_n) cnt_q <= 8'h00;
    else if (sck && !sck_q && cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || cs_n) op_q <= 8'h00;
    else if (sck && !sck_q && cnt_q < 8'h08) op_q <= {op_q[6:0], mosi};
  end
  idle_clock_low_a: assert property (cs_n |-> !sck)
    else $error("link clock high while deselected");
  whole_bytes_a: assert property ($rose(cs_n) |-> cnt_q[2:0] == 3'h0)
    else $error("frame not whole bytes");
  data_stable_a: assert property (sck && sck_q |-> $stable(mosi))
    else $error("data moved while clock high");
  start_low_a: assert property ($fell(cs_n) |-> !sck)
    else $error("frame began with clock high");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n[*4])
    else $error("deselect gap too short");
  opcode_quiet_a: assert property (!cs_n && cnt_q < 8'h08 |-> !miso_oe)
    else $error("output during opcode");
  release_out_a: assert property (cs_n |-> !miso_oe && so_line)
    else $error("output held while deselected");
  status_drive_a: assert property (
    !cs_n && op_q == 8'h05 && cnt_q == 8'h09 |-> miso_oe)
    else $error("status not driven");
  read_drive_a: assert property (
    !cs_n && op_q == 8'h03 && cnt_q == 8'h21 |-> miso_oe)
    else $error("read data not driven");
  dummy_quiet_a: assert property (
    !cs_n && op_q == 8'h0B && cnt_q inside {[8'h09:8'h27]} |-> !miso_oe)
    else $error("fast read drove too early");
  unknown_quiet_a: assert property (
    !cs_n && op_q == 8'h00 && cnt_q >= 8'h08 |-> !miso_oe)
    else $error("unknown opcode drove output");
endmodule : sfd_checker

// *** tb_top.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end
module tb_top;
  localparam int          AW  = 13;
  localparam logic [23:0] TOP = 24'h001FFF;
  localparam logic [7:0]  MID = 8'h3C; // arbitrary value
  localparam logic [7:0]  DID = 8'h81; // arbitrary value
  logic        clk_sys_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic        cv         = 1'b0;
  logic [7:0]  co         = 8'h00;
  logic [23:0] ca         = 24'h000000;
  logic [15:0] cd         = 16'h0000;
  logic [7:0]  cl         = 8'h00;
  logic        err, done, rv, busy, wl, ainc, rben, er, rdy;
  logic [7:0]  rd;
  logic [7:0]  rq[$];
  logic [31:0] seed       = 32'h0000EEC0;
  int          fails      = 0;
  int          num_checks = 0;
  sfd_if spi ();
  sfd_device #(.ADDR_W(AW), .MAN_ID(MID), .DEV_ID(DID)) i_sfd_device (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(1'b1), .spi(spi),
    .busy_out(busy), .write_latch_out(wl), .ainc_mode_out(ainc),
    .ready_not_busy_en_out(rben));
  sfd_host #(.HALF(4)) i_sfd_host (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .cmd_valid_in(cv), .cmd_op_in(co), .cmd_addr_in(ca), .cmd_data_in(cd),
    .cmd_rd_len_in(cl), .cmd_ready_out(rdy), .cmd_err_out(err),
    .done_out(done), .rd_data_out(rd), .rd_valid_out(rv), .spi(spi));
  sfd_checker i_sfd_checker (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .cs_n(spi.cs_n), .sck(spi.sck), .mosi(spi.mosi),
    .miso_oe(spi.miso_oe), .so_line(spi.so_line));
  always #2.5 clk_sys_in = ~clk_sys_in;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [7:0] stat(input logic l, input logic a);
    return {1'b0, a, 4'h0, l, 1'b0};
  endfunction : stat
  // waits for the device to go idle, issues one frame, collects read bytes
  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                     input logic [15:0] d, input logic [7:0] n);
    int t;
    t = 0;
    rq.delete();
    er = 1'b0;
    while (busy !== 1'b0 && t < 30000) begin
      @(negedge clk_sys_in);
      t++;
    end
    @(posedge clk_sys_in);
    cv <= 1'b1;
    co <= op;
    ca <= a;
    cd <= d;
    cl <= n;
    @(posedge clk_sys_in);
    cv <= 1'b0;
    while (t < 30000) begin
      @(negedge clk_sys_in);
      t++;
      if (rv === 1'b1) rq.push_back(rd);
      if (err === 1'b1) er = 1'b1;
      if (done === 1'b1 || err === 1'b1) break;
    end
    // let program or erase work finish before the caller looks at state
    while (busy !== 1'b0 && t < 30000) begin
      @(negedge clk_sys_in);
      t++;
    end
    if (t >= 30000) begin
      fails++;
      $display("wrong value at %0t: command timed out", $time);
    end
  endtask : cmd
  task automatic op1(input logic [7:0] op);
    cmd(op, 24'h000000, 16'h0000, 8'h00);
  endtask : op1
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial begin
    #450000;
    fails++;
    $display("wrong value at %0t: run timed out", $time);
    report_and_stop();
  end
  initial begin
    logic [7:0]  eo[4];
    logic [23:0] r;
    logic [15:0] d;
    eo = '{8'h20, 8'h52, 8'hD8, 8'hC7};
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    cmd(8'h05, 24'h000000, 16'h0000, 8'h03);
    `CHK(rq.size(), 3)
    foreach (rq[i]) `CHK(rq[i], stat(1'b0, 1'b0))
    cmd(8'h02, 24'h000100, 16'h5500, 8'h00);
    `CHK(er, 1'b1)
    op1(8'h06);
    cmd(8'h05, 24'h000000, 16'h0000, 8'h02);
    `CHK(rq[1], stat(1'b1, 1'b0))
    cmd(8'h35, 24'h000000, 16'h0000, 8'h01);
    `CHK(rq[0], 8'h00)
    op1(8'h60);
    `CHK(wl, 1'b0)
    $display("status and chip erase test ended");
    seed = xs(seed);
    d = seed[15:0];
    op1(8'h06);
    cmd(8'h02, TOP, {d[7:0], 8'h00}, 8'h00);
    op1(8'h06);
    cmd(8'h02, 24'h000000, {d[15:8], 8'h00}, 8'h00);
    cmd(8'h03, (TOP - 24'h000001) | (seed[31:8] & ~TOP), 16'h0000, 8'h03);
    `CHK({rq[0], rq[1], rq[2]}, {8'hFF, d[7:0], d[15:8]})
    cmd(8'h0B, TOP, 16'h0000, 8'h02);
    `CHK({rq[0], rq[1]}, {d[7:0], d[15:8]})
    $display("read and wrap test ended");
    seed = xs(seed);
    d = seed[15:0] & 16'h7F7F;
    op1(8'h06);
    cmd(8'hAD, 24'h000010, d, 8'h00);
    `CHK(ainc, 1'b1)
    cmd(8'h0B, 24'h000010, 16'h0000, 8'h01);
    `CHK(rq[0], 8'hFF)
    cmd(8'h05, 24'h000000, 16'h0000, 8'h01);
    `CHK(rq[0], stat(1'b1, 1'b1))
    cmd(8'hAD, 24'h000000, ~d, 8'h00);
    op1(8'h04);
    `CHK(ainc, 1'b0)
    cmd(8'h03, 24'h000010, 16'h0000, 8'h04);
    `CHK({rq[0], rq[1], rq[2], rq[3]}, {d, ~d})
    foreach (eo[i]) begin
      seed = xs(seed);
      r = seed[23:0] & TOP;
      op1(8'h06);
      cmd(8'h02, r, {seed[31:24] & 8'h7F, 8'h00}, 8'h00);
      op1(8'h06);
      cmd(eo[i], r ^ 24'h000FFF, 16'h0000, 8'h00);
      cmd(8'h03, r, 16'h0000, 8'h01);
      `CHK(rq[0], 8'hFF)
    end
    $display("program and erase test ended");
    for (int k = 0; k < 4; k++) begin
      cmd(k[1] ? 8'hAB : 8'h90, {23'h000000, k[0]}, 16'h0000, 8'h02);
      `CHK({rq[0], rq[1]}, {2{k[0] ? DID : MID}})
    end
    op1(8'h70);
    `CHK(rben, 1'b1)
    op1(8'h80);
    `CHK(rben, 1'b0)
    op1(8'h00);
    `CHK({er, wl, busy, rdy}, 4'h1)
    $display("identifier and mode test ended");
    report_and_stop();
  end
endmodule : tb_top
